//--- hw/blc_regs.sv
`timescale 1ns/1ps
`default_nettype none

module blc_regs
	import blc_pkg::*;
(
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic nrst_in,
	// two-wire serial pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out,
	// group assignment of channels five..three, from their current registers
	input wire logic [2:0] sink_grouped_in,
	// boost controls
	output logic boost_output_on_out,
	output logic led_mode_out,
	output logic bias_all_active_out,
	output logic bias_backlight_only_out,
	output logic fade_override_out,
	// sink controls, index 0 is channel two
	output logic [3:0] sink_on_out,
	output logic [3:0] group_member_out,
	output logic grouped_backlight_on_out
);

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisation and bus conditions

	logic [1:0] pins_sync;
	logic scl_q;
	logic sda_q;

	blc_sync2 u_sync (
		.ref_clk_in(ref_clk_in),
		.nrst_in(nrst_in),
		.async_in({scl_in, sda_in}),
		.sync_out(pins_sync)
	);

	wire scl_s = pins_sync[1];
	wire sda_s = pins_sync[0];
	wire scl_rise = scl_s && !scl_q;
	wire scl_fall = !scl_s && scl_q;
	wire bus_start = scl_s && scl_q && sda_q && !sda_s;
	wire bus_stop = scl_s && scl_q && !sda_q && sda_s;

	always_ff @(posedge ref_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end
		else
		begin
			scl_q <= scl_s;
			sda_q <= sda_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// register storage and read decode

	logic [7:0] led_ctrl;
	logic [7:0] boost_cfg;
	logic [7:0] ch2_cur;

	function automatic logic [7:0] read_mux(input logic [7:0] addr, input logic [7:0] a,
		input logic [7:0] b, input logic [7:0] c);
		logic [7:0] val;
		val = 8'h00;
		case (addr)
			BLC_OFS_LED_CTRL: val = a & BLC_MASK_LED_CTRL;
			BLC_OFS_BOOST_CFG: val = b & BLC_MASK_BOOST_CFG;
			BLC_OFS_CH2_CUR: val = c & BLC_MASK_CH2_CUR;
			default: val = 8'h00;
		endcase
		return val;
	endfunction : read_mux

	////////////////////////////////////////////////////////////////////////////////
	// serial engine

	blc_state_t state;
	blc_state_t next_state;
	logic [3:0] bit_cnt;
	logic [7:0] shreg;
	logic [7:0] tx;
	logic [7:0] ptr;
	logic read_dir;
	logic nack;
	logic drive_low;

	wire byte_full = (bit_cnt == BLC_BITS_PER_BYTE);
	wire addr_match = (shreg[7:1] == BLC_DEV_ADDR);
	wire wr_pulse = scl_fall && (state == BLC_WDATA) && byte_full;
	wire [7:0] rd_data = read_mux(ptr, led_ctrl, boost_cfg, ch2_cur);
	wire [7:0] ptr_inc = ptr + 8'h01;

	assign sda_out = 1'b0;
	assign sda_oe_out = drive_low;

	always_comb
	begin
		next_state = state;
		case (state)
			BLC_IDLE: next_state = BLC_IDLE;
			BLC_ADDR: if (byte_full) next_state = addr_match ? BLC_ADDR_ACK : BLC_IDLE;
			BLC_ADDR_ACK: next_state = read_dir ? BLC_RDATA : BLC_PTR;
			BLC_PTR: if (byte_full) next_state = BLC_PTR_ACK;
			BLC_PTR_ACK: next_state = BLC_WDATA;
			BLC_WDATA: if (byte_full) next_state = BLC_WDATA_ACK;
			BLC_WDATA_ACK: next_state = BLC_WDATA;
			BLC_RDATA: if (bit_cnt == BLC_LAST_TX_BIT) next_state = BLC_RACK;
			BLC_RACK: next_state = nack ? BLC_IDLE : BLC_RDATA;
			default: next_state = BLC_IDLE;
		endcase
	end

	// all changes on the data line happen after scl falls, well inside the low phase
	always_ff @(posedge ref_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			state <= BLC_IDLE;
			bit_cnt <= 4'h0;
			shreg <= 8'h00;
			tx <= 8'h00;
			ptr <= 8'h00;
			read_dir <= 1'b0;
			nack <= 1'b0;
			drive_low <= 1'b0;
		end
		else if (bus_start)
		begin
			state <= BLC_ADDR;
			bit_cnt <= 4'h0;
			drive_low <= 1'b0;
		end
		else if (bus_stop)
		begin
			state <= BLC_IDLE;
			drive_low <= 1'b0;
		end
		else if (scl_rise)
		begin
			if (state == BLC_RACK)
				nack <= sda_s;
			else if (state == BLC_ADDR || state == BLC_PTR || state == BLC_WDATA)
			begin
				shreg <= {shreg[6:0], sda_s};
				bit_cnt <= bit_cnt + 4'h1;
			end
		end
		else if (scl_fall)
		begin
			state <= next_state;
			case (next_state)
				BLC_ADDR_ACK, BLC_PTR_ACK, BLC_WDATA_ACK:
				begin
					drive_low <= 1'b1;
					if (state == BLC_ADDR)
						read_dir <= shreg[0];
					if (state == BLC_PTR)
						ptr <= shreg;
				end
				BLC_RDATA:
				begin
					if (state == BLC_RDATA)
					begin
						tx <= {tx[6:0], 1'b0};
						drive_low <= !tx[6];
						bit_cnt <= bit_cnt + 4'h1;
					end
					else
					begin
						tx <= rd_data;
						drive_low <= !rd_data[7];
						bit_cnt <= 4'h0;
					end
				end
				BLC_RACK:
				begin
					drive_low <= 1'b0;
					ptr <= ptr_inc;
				end
				default:
				begin
					drive_low <= 1'b0;
					// keep the count while a byte is still coming in
					if (next_state != state)
						bit_cnt <= 4'h0;
					// auto-increment after each written byte has been acknowledged
					if (state == BLC_WDATA_ACK)
						ptr <= ptr_inc;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// register writes

	wire wr_led_ctrl = wr_pulse && (ptr == BLC_OFS_LED_CTRL);
	wire wr_boost_cfg = wr_pulse && (ptr == BLC_OFS_BOOST_CFG);
	wire wr_ch2_cur = wr_pulse && (ptr == BLC_OFS_CH2_CUR);

	always_ff @(posedge ref_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			led_ctrl <= BLC_RST_LED_CTRL;
			boost_cfg <= BLC_RST_BOOST_CFG;
			ch2_cur <= BLC_RST_CH2_CUR;
		end
		else
		begin
			if (wr_led_ctrl)
				led_ctrl <= shreg & BLC_MASK_LED_CTRL;
			if (wr_boost_cfg)
				boost_cfg <= shreg & BLC_MASK_BOOST_CFG;
			if (wr_ch2_cur)
				ch2_cur <= shreg & BLC_MASK_CH2_CUR;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// control decode

	wire standalone = boost_cfg[BLC_BIT_MODE];
	wire [3:0] grouped = {sink_grouped_in, ch2_cur[BLC_BIT_CH2_GROUP]};
	wire [3:0] sink_en = led_ctrl[BLC_BIT_SINK_LO +: 4];
	wire next_boost_on = standalone && led_ctrl[BLC_BIT_BOOST_EN];
	wire [3:0] next_sink_on = sink_en & ~grouped;
	wire next_group_on = led_ctrl[BLC_BIT_GROUP_EN];
	wire next_bias_all = !standalone && !boost_cfg[BLC_BIT_SCOPE];
	wire next_bias_bl = !standalone && boost_cfg[BLC_BIT_SCOPE];
	wire next_fade = boost_cfg[BLC_BIT_FADE];

	// outputs are registered so the analog side sees no decode glitches
	always_ff @(posedge ref_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			boost_output_on_out <= 1'b0;
			led_mode_out <= 1'b1;
			bias_all_active_out <= 1'b1;
			bias_backlight_only_out <= 1'b0;
			fade_override_out <= 1'b0;
			sink_on_out <= 4'h0;
			group_member_out <= 4'h0;
			grouped_backlight_on_out <= 1'b0;
		end
		else
		begin
			boost_output_on_out <= next_boost_on;
			led_mode_out <= !standalone;
			bias_all_active_out <= next_bias_all;
			bias_backlight_only_out <= next_bias_bl;
			fade_override_out <= next_fade;
			sink_on_out <= next_sink_on;
			group_member_out <= grouped;
			grouped_backlight_on_out <= next_group_on;
		end
	end

endmodule : blc_regs

`default_nettype wire

//--- hw/blc_pkg.sv
package blc_pkg;

	// two-wire target address, arbitrary value
	localparam logic [6:0] BLC_DEV_ADDR = 7'h2A;

	// register offsets
	localparam logic [7:0] BLC_OFS_LED_CTRL = 8'h26;
	localparam logic [7:0] BLC_OFS_BOOST_CFG = 8'h27;
	localparam logic [7:0] BLC_OFS_CH2_CUR = 8'h29;

	// reset values
	localparam logic [7:0] BLC_RST_LED_CTRL = 8'h00;
	localparam logic [7:0] BLC_RST_BOOST_CFG = 8'h00;
	localparam logic [7:0] BLC_RST_CH2_CUR = 8'h00;

	// writable bits of each register
	localparam logic [7:0] BLC_MASK_LED_CTRL = 8'h3F;
	localparam logic [7:0] BLC_MASK_BOOST_CFG = 8'hE0;
	localparam logic [7:0] BLC_MASK_CH2_CUR = 8'h80;

	// led control fields
	localparam int BLC_BIT_BOOST_EN = 5;
	localparam int BLC_BIT_SINK_LO = 1;
	localparam int BLC_BIT_GROUP_EN = 0;

	// boost configuration fields
	localparam int BLC_BIT_MODE = 7;
	localparam int BLC_BIT_SCOPE = 6;
	localparam int BLC_BIT_FADE = 5;

	// channel two current register field
	localparam int BLC_BIT_CH2_GROUP = 7;

	// serial engine
	localparam logic [3:0] BLC_BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] BLC_LAST_TX_BIT = 4'h7;

	typedef enum logic [3:0] {
		BLC_IDLE,
		BLC_ADDR,
		BLC_ADDR_ACK,
		BLC_PTR,
		BLC_PTR_ACK,
		BLC_WDATA,
		BLC_WDATA_ACK,
		BLC_RDATA,
		BLC_RACK
	} blc_state_t;

endpackage : blc_pkg

//--- hw/blc_sync2.sv
`timescale 1ns/1ps
`default_nettype none

module blc_sync2
(
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic nrst_in,
	// asynchronous levels
	input wire logic [1:0] async_in,
	// synchronised levels
	output logic [1:0] sync_out
);

	logic [1:0] stage_one;

	always_ff @(posedge ref_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			stage_one <= 2'h3;
			sync_out <= 2'h3;
		end
		else
		begin
			stage_one <= async_in;
			sync_out <= stage_one;
		end
	end

endmodule : blc_sync2

`default_nettype wire

//--- verif/blc_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none
module blc_regs_properties
(
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic nrst_in,
	// watched inputs
	input wire logic scl_in,
	input wire logic [2:0] sink_grouped_in,
	// watched outputs
	input wire logic boost_output_on_out,
	input wire logic led_mode_out,
	input wire logic bias_all_active_out,
	input wire logic bias_backlight_only_out,
	input wire logic fade_override_out,
	input wire logic [3:0] sink_on_out,
	input wire logic [3:0] group_member_out,
	input wire logic grouped_backlight_on_out
);
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!nrst_in);
	////////////////////////////////////////////////////////////////
	property p_boost;
		boost_output_on_out |-> !led_mode_out;
	endproperty
	a_boost: assert property (p_boost) else $error("boost on in led mode");
	property p_scope;
		led_mode_out |-> (bias_all_active_out ^ bias_backlight_only_out);
	endproperty
	a_scope: assert property (p_scope) else $error("bias scope not one-hot");
	property p_ignore;
		!led_mode_out |-> !(bias_all_active_out | bias_backlight_only_out);
	endproperty
	a_ignore: assert property (p_ignore) else $error("bias scope in standalone");
	// both outputs are registered from the same membership, so no settling slack
	property p_excl;
		(sink_on_out & group_member_out) == 4'h0;
	endproperty
	a_excl: assert property (p_excl) else $error("grouped sink enabled");
	property p_follow;
		$changed(sink_grouped_in) |-> ##[1:3] group_member_out[3:1] == sink_grouped_in;
	endproperty
	a_follow: assert property (p_follow) else $error("membership not followed");
	// register writes land while the serial clock is low
	property p_mode_t;
		$changed(led_mode_out) |-> !scl_in;
	endproperty
	a_mode_t: assert property (p_mode_t) else $error("mode moved off a write");
	property p_fade_t;
		$changed(fade_override_out) |-> !scl_in;
	endproperty
	a_fade_t: assert property (p_fade_t) else $error("fade moved off a write");
	property p_grp_t;
		$changed(grouped_backlight_on_out) |-> !scl_in;
	endproperty
	a_grp_t: assert property (p_grp_t) else $error("group enable moved off a write");
	c_boost: cover property (boost_output_on_out);
	c_bl: cover property (bias_backlight_only_out);
	c_mix: cover property (sink_on_out == 4'h5);
endmodule : blc_regs_properties
bind blc_regs blc_regs_properties blc_regs_properties_inst (.ref_clk_in, .nrst_in, .scl_in,
	.sink_grouped_in, .boost_output_on_out, .led_mode_out, .bias_all_active_out,
	.bias_backlight_only_out, .fade_override_out, .sink_on_out, .group_member_out,
	.grouped_backlight_on_out);
`default_nettype wire

//--- verif/blc_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module blc_regs_tb;
	import blc_pkg::*;
	logic ref_clk_in = 1'b0;
	logic nrst_in = 1'b0;
	logic scl = 1'b1;
	logic sda_m = 1'b1;
	logic [2:0] grp = 3'h0;
	logic sda_out, sda_oe_out, b_on, l_md, b_all, b_bl, fade, g_on;
	logic [3:0] sink_on, member;
	int num_errors = 0;
	int cmp_count = 0;
	int cyc = 0;
	// pull-up wire: low when either party pulls
	wire logic sda_w = sda_m & (~sda_oe_out | sda_out);
	wire logic [7:0] ctl = {b_on, l_md, b_all, b_bl, fade, g_on, 2'h0};
	wire logic [7:0] snk = {sink_on, member};
	always #4 ref_clk_in = ~ref_clk_in;
	blc_regs blc_regs_inst (.ref_clk_in, .nrst_in, .scl_in(scl), .sda_in(sda_w), .sda_out,
		.sda_oe_out, .sink_grouped_in(grp), .boost_output_on_out(b_on), .led_mode_out(l_md),
		.bias_all_active_out(b_all), .bias_backlight_only_out(b_bl),
		.fade_override_out(fade), .sink_on_out(sink_on), .group_member_out(member),
		.grouped_backlight_on_out(g_on));
	////////////////////////////////////////////////////////////////
	task close_out;
		if (num_errors == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : close_out
	task wt(input int n);
		repeat (n) @(posedge ref_clk_in);
		#1;
	endtask : wt
	task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
		cmp_count++;
		if (s !== e)
		begin
			num_errors++;
			$display("wrong value %s exp %h seen %h", nm, e, s);
		end
	endtask : chk
	// scl high and low ten clocks each, above the eight-clock minimum
	task xbit(input logic b, output logic r);
		sda_m = b;
		wt(10);
		scl = 1'b1;
		wt(5);
		r = sda_w;
		wt(5);
		scl = 1'b0;
	endtask : xbit
	task xb(input logic [7:0] d, input logic a, output logic [7:0] r, output logic k);
		for (int i = 7; i >= 0; i--)
			xbit(d[i], r[i]);
		xbit(a, k);
	endtask : xb
	task sta;
		sda_m = 1'b1;
		wt(10);
		scl = 1'b1;
		wt(10);
		sda_m = 1'b0;
		wt(10);
		scl = 1'b0;
	endtask : sta
	task sto;
		sda_m = 1'b0;
		wt(10);
		scl = 1'b1;
		wt(10);
		sda_m = 1'b1;
		wt(10);
	endtask : sto
	task xa(input logic [7:0] d, output logic [7:0] r);
		logic k;
		xb(d, 1'b1, r, k);
		chk("ack", {7'h0, k}, 8'h00);
	endtask : xa
	task wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] r;
		sta;
		xa({BLC_DEV_ADDR, 1'b0}, r);
		xa(a, r);
		xa(d, r);
		sto;
	endtask : wr
	task rd(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] r;
		logic k;
		sta;
		xa({BLC_DEV_ADDR, 1'b0}, r);
		xa(a, r);
		sta;
		xa({BLC_DEV_ADDR, 1'b1}, r);
		xb(8'hFF, 1'b1, r, k);
		chk("rdata", r, e);
		sto;
	endtask : rd
	always @(posedge ref_clk_in)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			num_errors++;
			close_out;
		end
	end
	initial
	begin
		logic [7:0] r;
		logic k;
		wt(3);
		nrst_in = 1'b1;
		wt(3);
		chk("ctl", ctl, 8'h60);
		chk("snk", snk, 8'h00);
		rd(BLC_OFS_LED_CTRL, BLC_RST_LED_CTRL);
		rd(BLC_OFS_BOOST_CFG, BLC_RST_BOOST_CFG);
		wr(BLC_OFS_LED_CTRL, 8'hFF);
		rd(BLC_OFS_LED_CTRL, 8'h3F);
		chk("ctl", ctl, 8'h64);
		chk("snk", snk, 8'hF0);
		wr(BLC_OFS_BOOST_CFG, 8'hFF);
		rd(BLC_OFS_BOOST_CFG, 8'hE0);
		chk("ctl", ctl, 8'h8C);
		wr(BLC_OFS_BOOST_CFG, 8'h40);
		chk("ctl", ctl, 8'h54);
		grp = 3'h5;
		wt(3);
		chk("snk", snk, 8'h5A);
		wr(BLC_OFS_CH2_CUR, 8'hFF);
		rd(BLC_OFS_CH2_CUR, 8'h80);
		chk("snk", snk, 8'h4B);
		wr(8'h30, 8'hFF);
		rd(8'h30, 8'h00);
		rd(BLC_OFS_LED_CTRL, 8'h3F);
		// a foreign target address must be left unanswered
		sta;
		xb({BLC_DEV_ADDR ^ 7'h01, 1'b0}, 1'b1, r, k);
		sto;
		chk("nack", {7'h0, k}, 8'h01);
		wr(BLC_OFS_LED_CTRL, 8'h00);
		chk("ctl", ctl, 8'h50);
		chk("snk", snk, 8'h0B);
		// two data bytes in one transfer land in consecutive registers
		sta;
		xa({BLC_DEV_ADDR, 1'b0}, r);
		xa(BLC_OFS_LED_CTRL, r);
		xa(8'h21, r);
		xa(8'hA0, r);
		sto;
		chk("ctl", ctl, 8'h8C);
		chk("snk", snk, 8'h0B);
		// burst read, master acknowledges the first byte
		sta;
		xa({BLC_DEV_ADDR, 1'b0}, r);
		xa(BLC_OFS_LED_CTRL, r);
		sta;
		xa({BLC_DEV_ADDR, 1'b1}, r);
		xb(8'hFF, 1'b0, r, k);
		chk("rdata", r, 8'h21);
		xb(8'hFF, 1'b1, r, k);
		chk("rdata", r, 8'hA0);
		sto;
		// reset in mid-run brings every field back to its default
		nrst_in = 1'b0;
		wt(3);
		nrst_in = 1'b1;
		wt(3);
		chk("ctl", ctl, 8'h60);
		chk("snk", snk, 8'h0A);
		rd(BLC_OFS_LED_CTRL, BLC_RST_LED_CTRL);
		close_out;
	end
endmodule : blc_regs_tb
`default_nettype wire
